// ==== isps_chan_state.sv ====
/*
 * per-channel state: initial-state flag and instance id tracker.
 * assumes one instance per channel and one clock with sync reset.
 */
`timescale 1ns/1ps
`default_nettype none

module isps_chan_state
(
    input  wire logic       clk_i,      // system clock
    input  wire logic       reset_i,    // sync reset, active high
    input  wire logic       force_i,    // internal condition forces initial state
    input  wire logic       clear_i,    // clear initial state for this channel
    input  wire logic       take_i,     // command accepted for this channel
    input  wire logic [7:0] iid_i,      // instance id of that command
    output logic            initial_o,  // channel is in initial state
    output logic            retry_o     // iid_i repeats the last instance
);

    logic       init_reg;       // initial-state flag
    logic       last_vld_reg;   // last instance id is known
    logic [7:0] last_iid_reg;   // last instance id seen

    // initial state is entered at reset and on the internal condition
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            init_reg <= 1'b1;
        else if (force_i)
            init_reg <= 1'b1;
        else if (clear_i)
            init_reg <= 1'b0;
    end

    // a clear or force makes the next instance id a new one
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            last_vld_reg <= 1'b0;
        else if (clear_i || force_i)
            last_vld_reg <= 1'b0;
        else if (take_i)
            last_vld_reg <= 1'b1;
    end

    // remember the id of each accepted command
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            last_iid_reg <= 8'h00;
        else if (take_i)
            last_iid_reg <= iid_i;
    end

    assign initial_o = init_reg;
    assign retry_o   = last_vld_reg && (iid_i == last_iid_reg);

endmodule

`default_nettype wire

// ==== isps_consts.svh ====
/*
 * constants of the initial-state / package-select command block:
 * command codes, channel id fields, response codes, register map.
 * assumes it is included by bare name after the package.
 */
`ifndef ISPS_CONSTS_SVH
`define ISPS_CONSTS_SVH

// channel count and index width
`define ISPS_NUM_CHAN      4
`define ISPS_CH_W          2

// command and response type codes
`define ISPS_CMD_CLR_INIT  8'h00
`define ISPS_CMD_SEL_PKG   8'h01
`define ISPS_RSP_CLR_INIT  8'h80
`define ISPS_RSP_SEL_PKG   8'h81
`define ISPS_RSP_FLAG      8'h80

// channel id subfields
`define ISPS_PKG_HI        7
`define ISPS_PKG_LO        5
`define ISPS_ICH_HI        4
`define ISPS_ICH_LO        0
`define ISPS_ICH_PKG       5'h1F

// response and reason codes
`define ISPS_CODE_OK       16'h0000
`define ISPS_CODE_FAIL     16'h0001
`define ISPS_REASON_NONE   16'h0000
`define ISPS_REASON_INIT   16'h0001

// feature control byte bits
`define ISPS_FEAT_ARB_DIS  0
`define ISPS_FEAT_DLY_OK   1

// register byte offsets
`define ISPS_OFF_CTRL      12'h000
`define ISPS_OFF_STATUS    12'h004
`define ISPS_OFF_LASTRSP   12'h008

// control register fields and reset values
`define ISPS_CTRL_ARBCAP   0
`define ISPS_CTRL_PKG_HI   10
`define ISPS_CTRL_PKG_LO   8
`define ISPS_CTRL_FORCE    16
`define ISPS_ARBCAP_RST    1'b1
`define ISPS_PKG_RST       3'h0

// status register fields
`define ISPS_ST_SEL        0
`define ISPS_ST_ARBDIS     1
`define ISPS_ST_DLYOK      2
`define ISPS_ST_INIT_LO    8

`endif

// ==== isps_core.sv ====
/*
 * initial-state and package-select command handling for one package
 * of a sideband network controller, with an apb register port.
 * assumes commands arrive parsed and checksum-checked, one per cycle
 * at most, and that deselect and channel enable live elsewhere.
 */
`timescale 1ns/1ps
`include "isps_consts.svh"
`default_nettype none

module isps_core
    import isps_pkg::*;
(
    input  wire logic                     clk_i,          // 40 mhz clock
    input  wire logic                     reset_i,        // sync reset, active high
    input  wire logic                     psel_i,         // apb select
    input  wire logic                     penable_i,      // apb enable
    input  wire logic                     pwrite_i,       // apb write
    input  wire logic [11:0]              paddr_i,        // apb byte address
    input  wire logic [31:0]              pwdata_i,       // apb write data
    output logic      [31:0]              prdata_o,       // apb read data
    output logic                          pready_o,       // apb ready
    output logic                          pslverr_o,      // apb error
    input  wire isps_cmd_s                cmd_i,          // parsed command
    input  wire logic                     deselect_i,     // deselect done pulse
    input  wire logic                     internal_init_i, // internal reset condition
    input  wire logic                     tx_req_i,       // a packet is being sent
    input  wire logic [`ISPS_NUM_CHAN-1:0] chan_en_i,     // channel enabled
    input  wire logic [`ISPS_NUM_CHAN-1:0] chan_queued_i, // channel has packets
    output isps_rsp_s                     rsp_o,          // response out
    output isps_fwd_s                     fwd_o,          // command handed on
    output logic                          selected_o,     // package selected
    output logic                          tx_oe_o,        // output buffer enable
    output logic [`ISPS_NUM_CHAN-1:0]     chan_tx_o,      // channel may send
    output logic                          arb_bypass_o,   // arbitration in bypass
    output logic                          multi_sel_ok_o, // sharing bus is safe
    output logic                          delayed_ok_o,   // deferred reply allowed
    output logic [`ISPS_NUM_CHAN-1:0]     init_state_o    // channel initial state
);

    // registers
    logic                      selected_reg;   // package selected
    logic                      arb_dis_reg;    // arbitration disabled
    logic                      dly_ok_reg;     // deferred reply allowed
    logic                      arb_cap_reg;    // arbitration supported
    logic [2:0]                pkg_id_reg;     // our package id
    logic                      force_reg;      // software forced initial state
    logic                      pready_reg;     // apb ready flop
    logic                      pslverr_reg;    // apb error flop
    logic [31:0]               prdata_reg;     // apb read data flop
    logic [31:0]               lastrsp_reg;    // last response summary
    logic                      tx_oe_reg;      // output enable flop
    logic [`ISPS_NUM_CHAN-1:0] chan_tx_reg;    // per-channel send permission
    logic                      multi_reg;      // safe to share the bus
    isps_fwd_s                 fwd_reg;        // forwarded command flop

    // decode
    logic                      pkg_match;      // package id matches
    logic                      is_pkg;         // addressed to the package
    logic                      is_chan;        // addressed to a present channel
    logic                      addressed;      // command is for us
    logic [`ISPS_CH_W-1:0]     ch_idx;         // channel index
    logic                      force_all;      // force every channel initial
    logic [`ISPS_NUM_CHAN-1:0] init_vec;       // channel initial flags
    logic [`ISPS_NUM_CHAN-1:0] retry_vec;      // channel retry flags
    logic [`ISPS_NUM_CHAN-1:0] clear_vec;      // clear strobes
    logic [`ISPS_NUM_CHAN-1:0] take_vec;       // accepted command strobes
    logic                      rsp_valid;      // response due now
    logic [7:0]                rsp_type;       // response type
    logic [15:0]               rsp_code;       // response code
    logic [15:0]               rsp_reason;     // reason code
    logic                      fwd_valid;      // command handed on
    logic                      apb_access;     // apb access phase
    logic                      addr_ok;        // mapped address

    // address decode of the incoming command
    assign pkg_match = cmd_i.chan_id[`ISPS_PKG_HI:`ISPS_PKG_LO] == pkg_id_reg;
    assign is_pkg    = cmd_i.chan_id[`ISPS_ICH_HI:`ISPS_ICH_LO] == `ISPS_ICH_PKG;
    assign is_chan   = cmd_i.chan_id[`ISPS_ICH_HI:`ISPS_ICH_LO] < `ISPS_NUM_CHAN;
    assign ch_idx    = cmd_i.chan_id[`ISPS_CH_W-1:0];
    assign addressed = cmd_i.valid && pkg_match && (is_pkg || is_chan);
    assign force_all = internal_init_i || force_reg;

    // per-channel state, one instance per channel
    genvar g;
    generate
        for (g = 0; g < `ISPS_NUM_CHAN; g = g + 1)
        begin : g_chan
            // clear initial state only reads the header, no payload
            assign clear_vec[g] = addressed && is_chan && (ch_idx == g)
                                  && (cmd_i.cmd_type == `ISPS_CMD_CLR_INIT);
            assign take_vec[g]  = addressed && is_chan && (ch_idx == g) && !init_vec[g];

            isps_chan_state u_chan
            (
                .clk_i     (clk_i),
                .reset_i   (reset_i),
                .force_i   (force_all),
                .clear_i   (clear_vec[g]),
                .take_i    (take_vec[g]),
                .iid_i     (cmd_i.iid),
                .initial_o (init_vec[g]),
                .retry_o   (retry_vec[g])
            );

            // shared buffer: each channel still follows its own enable and queue
            always_ff @(posedge clk_i)
            begin
                if (reset_i)
                    chan_tx_reg[g] <= 1'b0;
                else
                    chan_tx_reg[g] <= selected_reg && chan_en_i[g] && chan_queued_i[g]
                                      && !init_vec[g];
            end
        end
    endgenerate

    // response decision for an addressed command
    always_comb
    begin
        rsp_valid  = 1'b0;
        rsp_type   = cmd_i.cmd_type | `ISPS_RSP_FLAG;
        rsp_code   = `ISPS_CODE_OK;
        rsp_reason = `ISPS_REASON_NONE;
        fwd_valid  = 1'b0;
        if (addressed)
        begin
            if (is_pkg && cmd_i.cmd_type == `ISPS_CMD_SEL_PKG)
            begin
                // select package, no command-specific reason
                rsp_valid = 1'b1;
                rsp_type  = `ISPS_RSP_SEL_PKG;
            end
            else if (is_chan && cmd_i.cmd_type == `ISPS_CMD_CLR_INIT)
            begin
                // clear initial state, no command-specific reason
                rsp_valid = 1'b1;
                rsp_type  = `ISPS_RSP_CLR_INIT;
            end
            else if (is_chan && init_vec[ch_idx])
            begin
                // channel still waits for clear initial state
                rsp_valid  = 1'b1;
                rsp_code   = `ISPS_CODE_FAIL;
                rsp_reason = `ISPS_REASON_INIT;
            end
            else
            begin
                // everything else goes to the other handlers
                fwd_valid = 1'b1;
            end
        end
    end

    // response register and frame word
    isps_rsp_fmt u_fmt
    (
        .clk_i    (clk_i),
        .reset_i  (reset_i),
        .valid_i  (rsp_valid),
        .type_i   (rsp_type),
        .chan_i   (cmd_i.chan_id),
        .iid_i    (cmd_i.iid),
        .code_i   (rsp_code),
        .reason_i (rsp_reason),
        .rsp_o    (rsp_o)
    );

    // forwarded command with retry flag from the channel tracker
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            fwd_reg <= '0;
        else
        begin
            fwd_reg.valid <= fwd_valid;
            fwd_reg.retry <= is_chan && retry_vec[ch_idx];
            fwd_reg.cmd   <= cmd_i;
        end
    end

    // package selected state
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            selected_reg <= 1'b0;
        else if (force_all)
            selected_reg <= 1'b0;
        else if (deselect_i)
            selected_reg <= 1'b0;
        else if (addressed)
            selected_reg <= 1'b1;
    end

    // arbitration and deferred-reply settings taken from select package
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            arb_dis_reg <= 1'b0;
            dly_ok_reg  <= 1'b0;
        end
        else if (addressed && is_pkg && cmd_i.cmd_type == `ISPS_CMD_SEL_PKG)
        begin
            // without arbitration support the bit is ignored, never an error
            arb_dis_reg <= arb_cap_reg ? cmd_i.features[`ISPS_FEAT_ARB_DIS] : 1'b1;
            dly_ok_reg  <= cmd_i.features[`ISPS_FEAT_DLY_OK];
        end
    end

    // output buffer: driven only while selected, tri-stated between packets
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            tx_oe_reg <= 1'b0;
        else
            tx_oe_reg <= selected_reg && tx_req_i;
    end

    // bus may be shared with other selected packages only under arbitration
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            multi_reg <= 1'b0;
        else
            multi_reg <= selected_reg && arb_cap_reg && !arb_dis_reg;
    end

    // last response summary for software
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            lastrsp_reg <= 32'h0000_0000;
        else if (rsp_valid)
            lastrsp_reg <= {rsp_type, cmd_i.iid, rsp_reason[7:0], rsp_code[7:0]};
    end

    // apb decode
    assign apb_access = psel_i && penable_i && !pready_reg;
    assign addr_ok    = (paddr_i == `ISPS_OFF_CTRL) || (paddr_i == `ISPS_OFF_STATUS)
                        || (paddr_i == `ISPS_OFF_LASTRSP);

    // apb ready: one wait state, then a one-cycle pready
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg  <= apb_access;
            pslverr_reg <= apb_access && !addr_ok;
        end
    end

    // control register writes
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            arb_cap_reg <= `ISPS_ARBCAP_RST;
            pkg_id_reg  <= `ISPS_PKG_RST;
        end
        else if (apb_access && pwrite_i && paddr_i == `ISPS_OFF_CTRL)
        begin
            arb_cap_reg <= pwdata_i[`ISPS_CTRL_ARBCAP];
            pkg_id_reg  <= pwdata_i[`ISPS_CTRL_PKG_HI:`ISPS_CTRL_PKG_LO];
        end
    end

    // software force of the internal condition, one-cycle pulse
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            force_reg <= 1'b0;
        else
            force_reg <= apb_access && pwrite_i && paddr_i == `ISPS_OFF_CTRL
                         && pwdata_i[`ISPS_CTRL_FORCE];
    end

    // read data, captured with pready
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            prdata_reg <= 32'h0000_0000;
        else if (apb_access && !pwrite_i)
        begin
            prdata_reg <= 32'h0000_0000;
            if (paddr_i == `ISPS_OFF_CTRL)
            begin
                prdata_reg[`ISPS_CTRL_ARBCAP]                   <= arb_cap_reg;
                prdata_reg[`ISPS_CTRL_PKG_HI:`ISPS_CTRL_PKG_LO] <= pkg_id_reg;
            end
            else if (paddr_i == `ISPS_OFF_STATUS)
            begin
                prdata_reg[`ISPS_ST_SEL]    <= selected_reg;
                prdata_reg[`ISPS_ST_ARBDIS] <= arb_dis_reg;
                prdata_reg[`ISPS_ST_DLYOK]  <= dly_ok_reg;
                prdata_reg[`ISPS_ST_INIT_LO +: `ISPS_NUM_CHAN] <= init_vec;
            end
            else if (paddr_i == `ISPS_OFF_LASTRSP)
                prdata_reg <= lastrsp_reg;
        end
    end

    // outputs straight from flops
    assign prdata_o       = prdata_reg;
    assign pready_o       = pready_reg;
    assign pslverr_o      = pslverr_reg;
    assign fwd_o          = fwd_reg;
    assign selected_o     = selected_reg;
    assign tx_oe_o        = tx_oe_reg;
    assign chan_tx_o      = chan_tx_reg;
    assign arb_bypass_o   = arb_dis_reg;
    assign multi_sel_ok_o = multi_reg;
    assign delayed_ok_o   = dly_ok_reg;
    assign init_state_o   = init_vec;

endmodule

`default_nettype wire

// ==== isps_core_chk.sv ====
/* port assertions for isps_core.
   assumes one clock, sync reset, and no force-init register write. */
`timescale 1ns/1ps
`default_nettype none
module isps_core_chk
    import isps_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       reset_i,
    input wire isps_cmd_s  cmd_i,
    input wire logic       deselect_i,
    input wire logic       internal_init_i,
    input wire isps_rsp_s  rsp_o,
    input wire isps_fwd_s  fwd_o,
    input wire logic       selected_o,
    input wire logic       tx_oe_o,
    input wire logic [3:0] chan_tx_o,
    input wire logic       arb_bypass_o,
    input wire logic       multi_sel_ok_o,
    input wire logic       delayed_ok_o,
    input wire logic [3:0] init_state_o
);
    // one domain, reset masks everything
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // command aimed at a single channel
    wire logic ch_cmd = cmd_i.valid && cmd_i.chan_id[4:0] < 5'h04;
    property p_rst; $past(reset_i) |-> init_state_o == 4'hF && !selected_o; endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_refuse; ch_cmd && cmd_i.cmd_type != 8'h00 && init_state_o[cmd_i.chan_id[1:0]]
        |=> !fwd_o.valid && (!rsp_o.valid || rsp_o.word16 == 32'h0001_0001); endproperty
    a_refuse: assert property (p_refuse) else $error("initial channel not refused");
    property p_clear; ch_cmd && cmd_i.cmd_type == 8'h00 ##1 rsp_o.valid |-> rsp_o.rsp_type == 8'h80
        && rsp_o.word16 == 32'h0 && !init_state_o[$past(cmd_i.chan_id[1:0])]; endproperty
    a_clear: assert property (p_clear) else $error("clear answer wrong");
    property p_new; rsp_o.valid && rsp_o.rsp_type == 8'h80 ##2 fwd_o.valid
        && fwd_o.cmd.chan_id == $past(rsp_o.chan_id, 2) |-> !fwd_o.retry; endproperty
    a_new: assert property (p_new) else $error("retry after clear");
    property p_sel; rsp_o.valid && rsp_o.rsp_type == 8'h81 && !$past(deselect_i) && !$past(internal_init_i)
        |-> rsp_o.word16 == 32'h0 && selected_o && delayed_ok_o == $past(cmd_i.features[1]); endproperty
    a_sel: assert property (p_sel) else $error("select answer wrong");
    property p_any; fwd_o.valid && !$past(deselect_i) && !$past(internal_init_i) |-> selected_o; endproperty
    a_any: assert property (p_any) else $error("command did not select");
    property p_oe; tx_oe_o || chan_tx_o != 4'h0 |-> selected_o || $past(selected_o); endproperty
    a_oe: assert property (p_oe) else $error("deselected package drives");
    property p_hold; selected_o && !deselect_i && !internal_init_i |=> selected_o; endproperty
    a_hold: assert property (p_hold) else $error("selection lost");
    // the sharing flag is registered from the previous cycle's selection and bypass state
    property p_multi; multi_sel_ok_o |-> $past(selected_o) && !$past(arb_bypass_o); endproperty
    a_multi: assert property (p_multi) else $error("sharing without arbitration");
    // main scenarios reached
    c_refuse: cover property (rsp_o.valid && rsp_o.word16 == 32'h0001_0001);
    c_retry: cover property (fwd_o.valid && fwd_o.retry);
    c_oe: cover property (tx_oe_o);
endmodule
bind isps_core isps_core_chk chk_u (.*);
`default_nettype wire

// ==== isps_core_test.sv ====
/* bench for isps_core: apb tasks and controller commands.
   assumes the controller model is the only command source. */
`timescale 1ns/1ps
`default_nettype none
module isps_core_test
    import isps_pkg::*;
;
    logic        clk_i, reset_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, e;
    logic        tx_req_i, internal_init_i, deselect_i, selected_o, tx_oe_o;
    logic        arb_bypass_o, multi_sel_ok_o, delayed_ok_o;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, q;
    logic [3:0]  chan_en_i, chan_queued_i, chan_tx_o, init_state_o;
    isps_cmd_s   cmd_i;
    isps_rsp_s   rsp_o;
    isps_fwd_s   fwd_o;
    int          bad_count, n_checks, cyc;
    isps_mc_model mc_u (.clk_i(clk_i), .cmd_o(cmd_i), .desel_o(deselect_i));
    isps_core dut_u (.*);
    // 25 ns clock
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic rsp_chk(input logic [7:0] t, input logic [31:0] w);
        #1;
        chk("rsp_valid", rsp_o.valid, 1);
        chk("rsp_type", rsp_o.rsp_type, t);
        chk("rsp_word", rsp_o.word16, w);
    endtask
    task automatic fwd_chk(input logic r);
        #1;
        chk("fwd_valid", fwd_o.valid, 1);
        chk("retry", fwd_o.retry, r);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // hang guard
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            bad_count++;
            end_of_test();
        end
    end
    initial
    begin
        reset_i = 1'b1;
        {psel_i, penable_i, pwrite_i, tx_req_i, internal_init_i} = '0;
        {paddr_i, pwdata_i, chan_en_i, chan_queued_i} = '0;
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        apb(0, 12'h004, 32'h0);
        chk("status", q, 32'h0000_0F00);
        apb(0, 12'h00C, 32'h0);
        chk("unmapped", {e, q[30:0]}, 32'h8000_0000);
        $display("reset test done");
        mc_u.send(8'h03, 8'h03, 8'h05, 8'h00);
        rsp_chk(8'h83, 32'h0001_0001);
        chk("selected", selected_o, 1);
        mc_u.send(8'h03, 8'h00, 8'h05, 8'h00);
        rsp_chk(8'h80, 32'h0);
        chk("init", init_state_o, 4'h7);
        mc_u.send(8'h03, 8'h03, 8'h05, 8'h00);
        fwd_chk(0);
        mc_u.send(8'h03, 8'h03, 8'h05, 8'h00);
        fwd_chk(1);
        mc_u.send(8'h03, 8'h00, 8'h05, 8'h00);
        rsp_chk(8'h80, 32'h0);
        mc_u.send(8'h03, 8'h03, 8'h05, 8'h00);
        fwd_chk(0);
        // every feature setting, reserved bits set
        for (int f = 0; f < 4; f++)
        begin
            mc_u.send(8'h1F, 8'h01, 8'h10, {6'h3F, f[1:0]});
            rsp_chk(8'h81, 32'h0);
            chk("bypass", arb_bypass_o, f[0]);
            chk("deferred", delayed_ok_o, f[1]);
        end
        apb(0, 12'h004, 32'h0);
        chk("status", q, 32'h0000_0707);
        apb(1, 12'h000, 32'h0);
        mc_u.send(8'h1F, 8'h01, 8'h11, 8'h00);
        rsp_chk(8'h81, 32'h0);
        chk("bypass", arb_bypass_o, 1);
        apb(1, 12'h000, 32'h0000_0101);
        mc_u.send(8'h1F, 8'h01, 8'h12, 8'h00);
        #1 chk("no_rsp", rsp_o.valid, 0);
        mc_u.send(8'h3F, 8'h01, 8'h12, 8'h00);
        rsp_chk(8'h81, 32'h0);
        apb(1, 12'h000, 32'h0000_0001);
        @(posedge clk_i);
        {tx_req_i, chan_en_i, chan_queued_i} <= {1'b1, 4'hF, 4'hA};
        repeat (2) @(posedge clk_i);
        #1 chk("oe", tx_oe_o, 1);
        chk("chan_tx", chan_tx_o, 4'h8);
        chk("multi", multi_sel_ok_o, 1);
        mc_u.desel();
        repeat (2) @(posedge clk_i);
        #1 chk("oe", tx_oe_o, 0);
        chk("multi", multi_sel_ok_o, 0);
        chk("selected", selected_o, 0);
        mc_u.send(8'h00, 8'h03, 8'h06, 8'h00);
        rsp_chk(8'h83, 32'h0001_0001);
        chk("selected", selected_o, 1);
        @(posedge clk_i);
        internal_init_i <= 1'b1;
        @(posedge clk_i);
        internal_init_i <= 1'b0;
        #1 chk("init", init_state_o, 4'hF);
        chk("selected", selected_o, 0);
        $display("command tests done");
        end_of_test();
    end
endmodule
`default_nettype wire

// ==== isps_mc_model.sv ====
/* management controller model: parsed commands and deselect pulses.
   assumes each call starts just after a clock edge. */
`timescale 1ns/1ps
`default_nettype none
module isps_mc_model
    import isps_pkg::*;
(
    input  wire logic clk_i,
    output var isps_cmd_s cmd_o,
    output var logic desel_o
);
    // idle before the first command
    initial
    begin
        cmd_o = '0;
        desel_o = 1'b0;
    end
    // one-cycle command; 0x1F in the channel field means the package
    task automatic send(input logic [7:0] ch, input logic [7:0] typ, input logic [7:0] iid, input logic [7:0] ft);
        logic [7:0] pay;
        pay = (typ == 8'h00) ? ~iid : ft; // clear carries no payload: junk byte
        @(posedge clk_i);
        cmd_o <= {1'b1, ch, typ, iid, pay};
        @(posedge clk_i);
        cmd_o <= {1'b0, ~ch, ~typ, ~iid, ~pay}; // released lines show junk
    endtask
    // deselect before choosing any other package
    task automatic desel();
        @(posedge clk_i);
        desel_o <= 1'b1;
        @(posedge clk_i);
        desel_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== isps_pkg.sv ====
/*
 * types of the initial-state / package-select command block.
 * assumes nothing beyond a systemverilog compiler.
 */
package isps_pkg;

    // one parsed command from the header parser
    typedef struct packed {
        logic       valid;     // one-cycle strobe
        logic [7:0] chan_id;   // package id and internal channel
        logic [7:0] cmd_type;  // command type
        logic [7:0] iid;       // instance id
        logic [7:0] features;  // first payload byte
    } isps_cmd_s;

    // one response towards the frame builder
    typedef struct packed {
        logic        valid;    // one-cycle strobe
        logic [7:0]  rsp_type; // response type
        logic [7:0]  chan_id;  // echoed channel id
        logic [7:0]  iid;      // echoed instance id
        logic [31:0] word16;   // frame bytes 16..19
    } isps_rsp_s;

    // a command handed on to other handlers
    typedef struct packed {
        logic       valid;     // one-cycle strobe
        logic       retry;     // same instance id as last time
        isps_cmd_s  cmd;       // the command itself
    } isps_fwd_s;

endpackage

// ==== isps_rsp_fmt.sv ====
/*
 * response formatter: packs code and reason into frame bytes 16..19
 * and registers the response. checksum and pad are added downstream.
 */
`timescale 1ns/1ps
`default_nettype none

module isps_rsp_fmt
    import isps_pkg::*;
(
    input  wire logic        clk_i,     // system clock
    input  wire logic        reset_i,   // sync reset, active high
    input  wire logic        valid_i,   // a response is due
    input  wire logic [7:0]  type_i,    // response type
    input  wire logic [7:0]  chan_i,    // channel id to echo
    input  wire logic [7:0]  iid_i,     // instance id to echo
    input  wire logic [15:0] code_i,    // response code
    input  wire logic [15:0] reason_i,  // reason code
    output isps_rsp_s        rsp_o      // registered response
);

    isps_rsp_s rsp_reg;   // response flop

    // code in the upper half, reason in the lower half
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            rsp_reg <= '0;
        else
        begin
            rsp_reg.valid    <= valid_i;
            rsp_reg.rsp_type <= type_i;
            rsp_reg.chan_id  <= chan_i;
            rsp_reg.iid      <= iid_i;
            rsp_reg.word16   <= {code_i, reason_i};
        end
    end

    assign rsp_o = rsp_reg;

endmodule

`default_nettype wire
